// ### verilog/dsf_consts.svh
// offsets, bit positions, reset values and timing of the status flag bank
`ifndef DSF_CONSTS_SVH
`define DSF_CONSTS_SVH

// ==========================================================================
// register numbers on the control bus
`define DSF_ADDR_POWER      8'h25
`define DSF_ADDR_GAIN       8'h26
`define DSF_ADDR_OVF        8'h27
`define DSF_ADDR_RSVD_A_LO  8'h28
`define DSF_ADDR_RSVD_A_HI  8'h2b
`define DSF_ADDR_INT_STICKY 8'h2c
`define DSF_ADDR_RSVD_B     8'h2d
`define DSF_ADDR_INT_LIVE   8'h2e
`define DSF_ADDR_RSVD_C     8'h2f

// ==========================================================================
// power state register fields
`define DSF_PWR_DAC_L  7
`define DSF_PWR_HP_L   5
`define DSF_PWR_CLD_L  4
`define DSF_PWR_DAC_R  3
`define DSF_PWR_HP_R   1
`define DSF_PWR_CLD_R  0

// gain settled register fields
`define DSF_GAIN_L     4
`define DSF_GAIN_R     0

// overflow register fields
`define DSF_OVF_L      7
`define DSF_OVF_R      6
`define DSF_OVF_SHIFT  5

// interrupt flag fields, shared by sticky and live registers
`define DSF_INT_SHORT_L  7
`define DSF_INT_SHORT_R  6
`define DSF_INT_BUTTON   5
`define DSF_INT_HEADSET  4
`define DSF_INT_DRC_L    3
`define DSF_INT_DRC_R    2

// ==========================================================================
// reset values
`define DSF_RST_BYTE     8'h00
`define DSF_RST_OVF      3'h0
`define DSF_RST_INT      6'h00

// ==========================================================================
// timing of the interrupt pulse
`define DSF_CLK_MHZ      125
`define DSF_PULSE_US     2000
`define DSF_PERIOD_US    4000

`endif

// ### verilog/dsf_pkg.sv
// types shared by the status flag bank modules
package dsf_pkg;

  // ========================================================================
  // bus data and address
  typedef logic [7:0] dsf_byte_t;
  typedef logic [7:0] dsf_addr_t;

  // ========================================================================
  // interrupt pulse sequencer states
  typedef enum logic [1:0] {
    DSF_PULSE_IDLE,
    DSF_PULSE_HIGH,
    DSF_PULSE_LOW
  } dsf_pulse_state_t;

endpackage

// ### verilog/dsf_vec_sync.sv
// three-stage synchroniser with agreement filter for a vector of levels
`timescale 1ns/100ps

module dsf_vec_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // levels from outside the clock domain
  input  wire logic [WIDTH-1:0] asyncIn,
  // filtered levels
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] mid_q;
  logic [WIDTH-1:0] late_q;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] agree;

  // ========================================================================
  // elaboration check
  if (WIDTH < 1) begin : gWidthCheck
    $error("dsf_vec_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      mid_q  <= '0;
      late_q <= '0;
    end else begin
      meta_q <= asyncIn;
      mid_q  <= meta_q;
      late_q <= mid_q;
    end
  end

  // a change counts only once stages two and three agree
  assign agree = ~(mid_q ^ late_q);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stable_q <= '0;
    end else begin
      stable_q <= (stable_q & ~agree) | (mid_q & agree);
    end
  end

  assign syncOut = stable_q;

endmodule

// ### verilog/dsf_pulse_gen.sv
// single or repeating interrupt pulse sequencer
`timescale 1ns/100ps

module dsf_pulse_gen #(
  parameter int PULSE_CYC  = 250000,
  parameter int PERIOD_CYC = 500000
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // control
  input  wire logic trigger,
  input  wire logic repeatMode,
  input  wire logic stopReq,
  // pulse output, active high
  output logic      pulseOut
);
  import dsf_pkg::*;

  localparam int CW = $clog2(PERIOD_CYC + 1);

  dsf_pulse_state_t state_q;
  logic [CW-1:0]    cnt_q;

  // ========================================================================
  // elaboration check
  if (PULSE_CYC < 1 || PULSE_CYC >= PERIOD_CYC) begin : gTimeCheck
    $error("dsf_pulse_gen: need 1 <= PULSE_CYC < PERIOD_CYC");
  end

  // a new event restarts the train; a read ends only a repeating train
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= DSF_PULSE_IDLE;
      cnt_q   <= '0;
    end else if (trigger) begin
      state_q <= DSF_PULSE_HIGH;
      cnt_q   <= '0;
    end else if (stopReq && repeatMode) begin
      state_q <= DSF_PULSE_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        DSF_PULSE_IDLE: begin
          cnt_q <= '0;
        end
        DSF_PULSE_HIGH: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CW'(PULSE_CYC - 1)) begin
            state_q <= repeatMode ? DSF_PULSE_LOW : DSF_PULSE_IDLE;
          end
        end
        DSF_PULSE_LOW: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CW'(PERIOD_CYC - 1)) begin
            state_q <= DSF_PULSE_HIGH;
            cnt_q   <= '0;
          end
        end
        default: begin
          state_q <= DSF_PULSE_IDLE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  assign pulseOut = (state_q == DSF_PULSE_HIGH);

endmodule

// ### verilog/dsf_status_bank.sv
// status, overflow and interrupt flag register bank of the stereo dac
//
// Functional notes
// - bit 7 of power status: left dac powered
// - bit 5 of power status: left headphone driver
// - bit 4 of power status: left class-d driver
// - bit 3 of power status: right dac powered
// - bit 1 of power status: right headphone driver
// - bit 0 of power status: right class-d driver
// - gain bit 4: left applied equals programmed
// - gain bit 0: right applied equals programmed
// - overflow bit 7: left dac overflow sticky
// - overflow bit 6: right dac overflow sticky
// - overflow bit 5: barrel shifter overflow sticky
// - sticky flags hold, clear on read, re-arm
// - sticky bit 7: left short circuit
// - sticky bit 6: right short circuit
// - bit 5 sticky and live: headset button
// - sticky bit 4: headset inserted or removed
// - sticky bit 3: left power above threshold
// - sticky bit 2: right power above threshold
// - live bits 7 and 6: current shorts
// - live bit 4: headset present
// - live bits 3,2: powers above compressor threshold
// - repeat mode pulses 2 ms per 4 ms
`timescale 1ns/100ps
`include "dsf_consts.svh"

module dsf_status_bank #(
  parameter int GAIN_W     = 8,
  parameter int PULSE_CYC  = `DSF_PULSE_US * `DSF_CLK_MHZ,
  parameter int PERIOD_CYC = `DSF_PERIOD_US * `DSF_CLK_MHZ
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // register read port from the control bus engine
  input  wire logic                regRdEn,
  input  wire dsf_pkg::dsf_addr_t  regAddr,
  output dsf_pkg::dsf_byte_t       regRdData,
  output logic                     regRdValid,
  // power state of channels and drivers, core domain
  input  wire logic                dacLeftPowered,
  input  wire logic                leftHeadphoneDriverPowered,
  input  wire logic                leftClassdPowered,
  input  wire logic                dacRightPowered,
  input  wire logic                rightHeadphoneDriverPowered,
  input  wire logic                rightClassdPowered,
  // gain stage state, core domain
  input  wire logic [GAIN_W-1:0]   appliedGainLeft,
  input  wire logic [GAIN_W-1:0]   programmedGainLeft,
  input  wire logic [GAIN_W-1:0]   appliedGainRight,
  input  wire logic [GAIN_W-1:0]   programmedGainRight,
  // overflow events, one-cycle pulses, core domain
  input  wire logic                leftDacOverflow,
  input  wire logic                rightDacOverflow,
  input  wire logic                shifterOverflow,
  // analog detector levels, asynchronous
  input  wire logic                leftHeadphoneDriverShort,
  input  wire logic                leftClassdShort,
  input  wire logic                rightHeadphoneDriverShort,
  input  wire logic                rightClassdShort,
  input  wire logic                headsetButton,
  input  wire logic                headsetInserted,
  input  wire logic                dynamicCompressorAboveLeft,
  input  wire logic                dynamicCompressorAboveRight,
  // interrupt pulse control and output
  input  wire logic                intRepeatMode,
  output logic                     interruptOutputOne
);
  import dsf_pkg::*;

  // ========================================================================
  // elaboration check
  if (GAIN_W < 1) begin : gGainCheck
    $error("dsf_status_bank: GAIN_W must be at least 1");
  end

  // ========================================================================
  // helpers

  // the gain stage has settled when applied and programmed codes match
  function automatic logic gainMatch(input logic [GAIN_W-1:0] applied,
                                     input logic [GAIN_W-1:0] programmed);
    gainMatch = (applied == programmed);
  endfunction

  // decode of one register number against the read strobe
  function automatic logic rdHit(input logic en,
                                 input dsf_addr_t addr,
                                 input dsf_addr_t target);
    rdHit = en && (addr == target);
  endfunction

  // ========================================================================
  // detector synchronisation
  logic [7:0] detRaw;
  logic [7:0] detSync;

  assign detRaw = {leftHeadphoneDriverShort, leftClassdShort,
                   rightHeadphoneDriverShort, rightClassdShort,
                   headsetButton, headsetInserted,
                   dynamicCompressorAboveLeft, dynamicCompressorAboveRight};

  dsf_vec_sync #(
    .WIDTH (8)
  ) uDetSync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .asyncIn  (detRaw),
    .syncOut  (detSync)
  );

  // live conditions, either driver of a side counts as that side's short
  logic liveShortL;
  logic liveShortR;
  logic liveButton;
  logic liveHeadset;
  logic liveDrcL;
  logic liveDrcR;

  assign liveShortL  = detSync[7] | detSync[6];
  assign liveShortR  = detSync[5] | detSync[4];
  assign liveButton  = detSync[3];
  assign liveHeadset = detSync[2];
  assign liveDrcL    = detSync[1];
  assign liveDrcR    = detSync[0];

  // previous copy of the live vector for edge detection
  logic [5:0] livePrev_q;
  logic [5:0] liveNow;

  assign liveNow = {liveShortL, liveShortR, liveButton,
                    liveHeadset, liveDrcL, liveDrcR};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      livePrev_q <= `DSF_RST_INT;
    end else begin
      livePrev_q <= liveNow;
    end
  end

  // ========================================================================
  // read strobes; a read of a sticky register is also its clear
  logic rdOvf;
  logic rdIntSticky;

  assign rdOvf       = rdHit(regRdEn, regAddr, `DSF_ADDR_OVF);
  assign rdIntSticky = rdHit(regRdEn, regAddr, `DSF_ADDR_INT_STICKY);

  // ========================================================================
  // overflow sticky flags, order {left, right, shifter}
  logic [2:0] ovfSticky_q;
  logic [2:0] ovfSet;

  assign ovfSet = {leftDacOverflow, rightDacOverflow, shifterOverflow};

  // set wins over the read clear so no overflow is lost
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ovfSticky_q <= `DSF_RST_OVF;
    end else begin
      ovfSticky_q <= (ovfSticky_q & ~{3{rdOvf}}) | ovfSet;
    end
  end

  // ========================================================================
  // interrupt sticky flags, order as liveNow
  logic [5:0] intSticky_q;
  logic [5:0] intSet;

  // rising edges, both edges for the headset, so a lasting condition does not re-arm after a read
  assign intSet[5] = liveShortL & ~livePrev_q[5];
  assign intSet[4] = liveShortR & ~livePrev_q[4];
  assign intSet[3] = liveButton & ~livePrev_q[3];
  assign intSet[2] = liveHeadset ^ livePrev_q[2];
  assign intSet[1] = liveDrcL & ~livePrev_q[1];
  assign intSet[0] = liveDrcR & ~livePrev_q[0];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      intSticky_q <= `DSF_RST_INT;
    end else begin
      intSticky_q <= (intSticky_q & ~{6{rdIntSticky}}) | intSet;
    end
  end

  // ========================================================================
  // read word assembly; reserved and unmapped registers read zero
  dsf_byte_t rdWord;

  always_comb begin
    rdWord = `DSF_RST_BYTE;
    case (regAddr)
      `DSF_ADDR_POWER: begin
        rdWord[`DSF_PWR_DAC_L] = dacLeftPowered;
        rdWord[`DSF_PWR_HP_L]  = leftHeadphoneDriverPowered;
        rdWord[`DSF_PWR_CLD_L] = leftClassdPowered;
        rdWord[`DSF_PWR_DAC_R] = dacRightPowered;
        rdWord[`DSF_PWR_HP_R]  = rightHeadphoneDriverPowered;
        rdWord[`DSF_PWR_CLD_R] = rightClassdPowered;
      end
      `DSF_ADDR_GAIN: begin
        rdWord[`DSF_GAIN_L] = gainMatch(appliedGainLeft,
                                        programmedGainLeft);
        rdWord[`DSF_GAIN_R] = gainMatch(appliedGainRight,
                                        programmedGainRight);
      end
      `DSF_ADDR_OVF: begin
        rdWord[`DSF_OVF_L]     = ovfSticky_q[2];
        rdWord[`DSF_OVF_R]     = ovfSticky_q[1];
        rdWord[`DSF_OVF_SHIFT] = ovfSticky_q[0];
      end
      `DSF_ADDR_INT_STICKY: begin
        rdWord[`DSF_INT_SHORT_L] = intSticky_q[5];
        rdWord[`DSF_INT_SHORT_R] = intSticky_q[4];
        rdWord[`DSF_INT_BUTTON]  = intSticky_q[3];
        rdWord[`DSF_INT_HEADSET] = intSticky_q[2];
        rdWord[`DSF_INT_DRC_L]   = intSticky_q[1];
        rdWord[`DSF_INT_DRC_R]   = intSticky_q[0];
      end
      `DSF_ADDR_INT_LIVE: begin
        // plain views of the conditions, reading them changes nothing
        rdWord[`DSF_INT_SHORT_L] = liveShortL;
        rdWord[`DSF_INT_SHORT_R] = liveShortR;
        rdWord[`DSF_INT_BUTTON]  = liveButton;
        rdWord[`DSF_INT_HEADSET] = liveHeadset;
        rdWord[`DSF_INT_DRC_L]   = liveDrcL;
        rdWord[`DSF_INT_DRC_R]   = liveDrcR;
      end
      default: begin
        rdWord = `DSF_RST_BYTE;
      end
    endcase
  end

  // ========================================================================
  // read data register; captured before the clear of the same edge
  dsf_byte_t regRdData_q;
  logic      regRdValid_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData_q <= `DSF_RST_BYTE;
    end else if (regRdEn) begin
      regRdData_q <= rdWord;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= regRdEn;
    end
  end

  assign regRdData  = regRdData_q;
  assign regRdValid = regRdValid_q;

  // ========================================================================
  // interrupt pulse; any new interrupt source starts it
  logic intEvent;

  assign intEvent = |intSet;

  dsf_pulse_gen #(
    .PULSE_CYC  (PULSE_CYC),
    .PERIOD_CYC (PERIOD_CYC)
  ) uPulse (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .trigger    (intEvent),
    .repeatMode (intRepeatMode),
    .stopReq    (rdIntSticky),
    .pulseOut   (interruptOutputOne)
  );

  // ========================================================================
  // assertions
  default clocking dsfCb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  AST_OVF_LEFT_SET: assert property (
    leftDacOverflow |=> ovfSticky_q[2]
  ) else $error("left overflow flag not set");

  AST_OVF_READ_CLEAR: assert property (
    (rdOvf && !(|ovfSet)) |=> (ovfSticky_q == 3'h0)
  ) else $error("overflow flags not cleared by read");

  AST_OVF_HOLD: assert property (
    (ovfSticky_q[1] && !rdOvf) |=> ovfSticky_q[1]
  ) else $error("right overflow flag dropped without read");

  AST_SHORT_LEFT_SET: assert property (
    $rose(liveShortL) |=> intSticky_q[5]
  ) else $error("left short sticky flag not set");

  AST_HEADSET_CHANGE: assert property (
    $changed(liveHeadset) |=> intSticky_q[2]
  ) else $error("headset change not latched");

  AST_NO_REARM: assert property (
    (rdIntSticky && !(|intSet)) ##1 ($stable(liveNow) [*2])
      |-> (intSticky_q == 6'h00)
  ) else $error("sticky flag re-armed without new event");

  AST_READ_POWER: assert property (
    rdHit(regRdEn, regAddr, `DSF_ADDR_POWER)
      |=> regRdData[`DSF_PWR_DAC_L] == $past(dacLeftPowered)
          && regRdData[6] == 1'b0
  ) else $error("power status read wrong");

  AST_READ_GAIN: assert property (
    rdHit(regRdEn, regAddr, `DSF_ADDR_GAIN)
      |=> regRdData[`DSF_GAIN_L] ==
          $past(appliedGainLeft == programmedGainLeft)
  ) else $error("left gain settled bit wrong");

  AST_READ_LIVE_DRC: assert property (
    rdHit(regRdEn, regAddr, `DSF_ADDR_INT_LIVE)
      |=> regRdData[`DSF_INT_DRC_R] == $past(liveDrcR)
          && regRdData[1:0] == 2'b00
  ) else $error("live compressor bit wrong");

  // a read of a plain register answers and leaves every flag alone
  AST_READ_VALID: assert property (
    (regRdEn && !rdOvf && !rdIntSticky && !(|intSet) && !(|ovfSet))
      |=> regRdValid && $stable(intSticky_q) && $stable(ovfSticky_q)
  ) else $error("read of a plain register disturbed a flag");

  // a sticky read ends a repeating train unless a new event restarts it
  AST_INT_STOP: assert property (
    (rdIntSticky && intRepeatMode && !intEvent) |=> !interruptOutputOne
  ) else $error("repeating interrupt train not ended by sticky read");

  AST_INT_START: assert property (
    intEvent |=> interruptOutputOne
  ) else $error("interrupt pulse not started by event");

endmodule

// ### test/dsf_host_model.sv
// host side model that issues single-byte reads on the register read port
`timescale 1ns/100ps

module dsf_host_model (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               resetn,
  // read request towards the bank
  output logic                    regRdEn,
  output dsf_pkg::dsf_addr_t      regAddr,
  // answer from the bank
  input  wire dsf_pkg::dsf_byte_t regRdData,
  input  wire logic               regRdValid
);
  import dsf_pkg::*;

  // ==========================================================================
  // idle state of the request lines
  initial begin
    regRdEn = 1'b0;
    regAddr = 8'h00;
  end

  // ==========================================================================
  // one strobe cycle, then the answer is taken in the cycle it stands
  task automatic rd(input dsf_addr_t addr, output dsf_byte_t data);
    int waitCnt;
    waitCnt = 0;
    @(posedge core_clk);
    #1;
    regAddr = addr;
    regRdEn = 1'b1;
    @(posedge core_clk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~addr; // scrambled so a stale address cannot pass for a hold
    // bounded wait; a missing answer comes back unknown and fails compares
    while (regRdValid !== 1'b1 && waitCnt < 4) begin
      @(posedge core_clk);
      #1;
      waitCnt++;
    end
    data = (regRdValid === 1'b1) ? regRdData : 8'hxx;
  endtask
endmodule

// ### test/dsf_status_bank_bench.sv
// self-checking bench for the status flag bank
`timescale 1ns/100ps

module dsf_status_bank_bench;
  import dsf_pkg::*;

  // ==========================================================================
  // stimulus, answers and bookkeeping
  logic       core_clk            = 1'b0;
  logic       resetn              = 1'b0;
  logic       regRdEn;
  dsf_addr_t  regAddr;
  dsf_byte_t  regRdData;
  logic       regRdValid;
  logic [5:0] pwrVec              = 6'h00;
  logic [2:0] ovfVec              = 3'h0;
  logic [7:0] detVec              = 8'h00;
  logic [7:0] appliedGainLeft     = 8'h00;
  logic [7:0] programmedGainLeft  = 8'h00;
  logic [7:0] appliedGainRight    = 8'h00;
  logic [7:0] programmedGainRight = 8'h00;
  logic       intRepeatMode       = 1'b0;
  logic       interruptOutputOne;
  int         numErrors           = 0;
  int         checksDone          = 0;
  int         n;

  localparam dsf_byte_t PWR_BIT [6] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20,
                                        8'h80};
  localparam dsf_byte_t DET_BIT [8] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h20,
                                        8'h10, 8'h08, 8'h04};
  localparam dsf_addr_t ZERO_AT [7] = '{8'h27, 8'h28, 8'h2b, 8'h2c, 8'h2d,
                                        8'h2e, 8'h2f};

  // free running 125 MHz clock
  always #4 core_clk = ~core_clk;

  // ==========================================================================
  // device and host
  dsf_status_bank #(
    .PULSE_CYC  (4),
    .PERIOD_CYC (8)
  ) dut_u (
    .core_clk                    (core_clk),
    .resetn                      (resetn),
    .regRdEn                     (regRdEn),
    .regAddr                     (regAddr),
    .regRdData                   (regRdData),
    .regRdValid                  (regRdValid),
    .dacLeftPowered              (pwrVec[5]),
    .leftHeadphoneDriverPowered  (pwrVec[4]),
    .leftClassdPowered           (pwrVec[3]),
    .dacRightPowered             (pwrVec[2]),
    .rightHeadphoneDriverPowered (pwrVec[1]),
    .rightClassdPowered          (pwrVec[0]),
    .appliedGainLeft             (appliedGainLeft),
    .programmedGainLeft          (programmedGainLeft),
    .appliedGainRight            (appliedGainRight),
    .programmedGainRight         (programmedGainRight),
    .leftDacOverflow             (ovfVec[2]),
    .rightDacOverflow            (ovfVec[1]),
    .shifterOverflow             (ovfVec[0]),
    .leftHeadphoneDriverShort    (detVec[0]),
    .leftClassdShort             (detVec[1]),
    .rightHeadphoneDriverShort   (detVec[2]),
    .rightClassdShort            (detVec[3]),
    .headsetButton               (detVec[4]),
    .headsetInserted             (detVec[5]),
    .dynamicCompressorAboveLeft  (detVec[6]),
    .dynamicCompressorAboveRight (detVec[7]),
    .intRepeatMode               (intRepeatMode),
    .interruptOutputOne          (interruptOutputOne)
  );

  dsf_host_model host_u (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .regRdEn    (regRdEn),
    .regAddr    (regAddr),
    .regRdData  (regRdData),
    .regRdValid (regRdValid)
  );

  // ==========================================================================
  // helpers
  task automatic waitCyc(input int cyc);
    repeat (cyc) @(posedge core_clk);
    #1;
  endtask

  task automatic chkByte(input dsf_byte_t got, input dsf_byte_t exp);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %0t read data %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chkCount(input int got, input int exp);
    checksDone++;
    if (got != exp) begin
      numErrors++;
      $display("[ERR] %0t pulse count %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic rdChk(input dsf_addr_t addr, input dsf_byte_t exp);
    dsf_byte_t got;
    host_u.rd(addr, got);
    chkByte(got, exp);
  endtask

  // high cycles of the interrupt output over a 16 cycle window
  task automatic cntWin(output int hi);
    hi = 0;
    repeat (16) begin
      hi += (interruptOutputOne === 1'b1);
      waitCyc(1);
    end
  endtask

  // same window, opened at the first high cycle (bounded wait)
  task automatic cntPulse(output int hi);
    int k;
    k = 0;
    while (interruptOutputOne !== 1'b1 && k < 20) begin
      waitCyc(1);
      k++;
    end
    cntWin(hi);
  endtask

  task automatic conclude();
    if (numErrors == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    waitCyc(6);
    // flags clear after reset, reserved places read zero
    foreach (ZERO_AT[i]) rdChk(ZERO_AT[i], 8'h00);
    // each power state bit alone, then all together, read twice
    for (int i = 0; i < 6; i++) begin
      pwrVec = 6'(1 << i);
      waitCyc(2);
      rdChk(8'h25, PWR_BIT[i]);
    end
    pwrVec = 6'h3f;
    waitCyc(2);
    rdChk(8'h25, 8'hbb);
    rdChk(8'h25, 8'hbb);
    // gains differing in the top or bottom bit must not count as equal
    for (int i = 0; i < 4; i++) begin
      appliedGainLeft     = 8'h3c;
      programmedGainLeft  = i[0] ? 8'h3c : 8'h3d;
      appliedGainRight    = 8'hc3;
      programmedGainRight = i[1] ? 8'hc3 : 8'h43;
      waitCyc(2);
      rdChk(8'h26, {3'h0, i[0], 3'h0, i[1]});
    end
    // single overflow pulses and all three together, cleared by a read
    for (int i = 0; i < 4; i++) begin
      ovfVec = (i == 3) ? 3'h7 : 3'(1 << i);
      waitCyc(1);
      ovfVec = 3'h0;
      waitCyc(4);
      rdChk(8'h27, (i == 3) ? 8'he0 : 8'(8'h20 << i));
      rdChk(8'h27, 8'h00);
    end
    // each detector: live level, sticky latch, clear, release
    for (int i = 0; i < 8; i++) begin
      detVec[i] = 1'b1;
      waitCyc(6);
      rdChk(8'h2e, DET_BIT[i]);
      rdChk(8'h2c, DET_BIT[i]);
      rdChk(8'h2c, 8'h00);
      rdChk(8'h2e, DET_BIT[i]);
      detVec[i] = 1'b0;
      waitCyc(6);
      rdChk(8'h2e, 8'h00);
      rdChk(8'h2c, (i == 5) ? DET_BIT[i] : 8'h00);
    end
    // single pulse mode gives one pulse only
    detVec[4] = 1'b1;
    cntPulse(n);
    chkCount(n, 4);
    rdChk(8'h2c, 8'h20);
    // repeat mode: two full periods, then a sticky read stops the train
    intRepeatMode = 1'b1;
    detVec[7] = 1'b1;
    cntPulse(n);
    chkCount(n, 8);
    rdChk(8'h2c, 8'h04);
    cntWin(n);
    chkCount(n, 0);
    conclude();
  end

  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    numErrors++;
    conclude();
  end
endmodule
